// ---- switch_array_pkg.sv ----
// switch array control constants
package switch_array_pkg;

    // ----------------------------------------------------------------
    // array geometry
    // ----------------------------------------------------------------
    localparam int          N_SWITCH      = 32;            // switches and shift stages
    localparam int          LAST_STAGE    = 31;            // stage that feeds the cascade output
    localparam logic [31:0] EVEN_MASK     = 32'h5555_5555; // switches 0, 2, 4 ... 30
    localparam logic [31:0] ODD_MASK      = 32'hAAAA_AAAA; // switches 1, 3, 5 ... 31
    localparam logic [31:0] ALL_OFF       = 32'h0000_0000; // every switch open

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 25;            // 40 MHz system clock
    localparam int          WAKE_TIME_NS  = 10000;         // standby wake-up time, 10 us
    localparam int          WAKE_CYC      = WAKE_TIME_NS / CLK_PERIOD_NS; // longest time, rounds down
    localparam int          WAKE_W        = 9;             // counter width, holds WAKE_CYC

    // ----------------------------------------------------------------
    // register map, byte addresses of aligned 32-bit words
    // ----------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;         // software control
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;         // block state flags
    localparam logic [7:0]  ADDR_SHIFT    = 8'h08;         // shift register contents
    localparam logic [7:0]  ADDR_LATCH    = 8'h0C;         // latch contents
    localparam logic [7:0]  ADDR_SWITCH   = 8'h10;         // switch drive as applied

    // control register fields
    localparam int          CTRL_SOFT_CLEAR   = 0;         // acts like the clear pin
    localparam int          CTRL_SOFT_STANDBY = 1;         // forces standby like the hold pin
    localparam logic [1:0]  CTRL_RESET        = 2'h0;      // reset value of control bits

    // status register fields
    localparam int          STAT_MODE_IND = 0;             // individual mode selected
    localparam int          STAT_STANDBY  = 1;             // standby in force
    localparam int          STAT_WAKE_OK  = 2;             // wake-up time has elapsed
    localparam int          STAT_CASCADE  = 3;             // cascade output level

    // ahb-lite encodings
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;          // bit 1 marks an active transfer
    localparam logic        HRESP_OKAY    = 1'h0;          // the only response given

endpackage

// ---- rise_detect.sv ----
// rising edge detector for a group of synchronous inputs
`timescale 1ns/10ps
module rise_detect #(
    parameter int W = 1 // number of inputs watched
) (
    input  wire logic         i_clk,   // system clock
    input  wire logic         i_rst_b, // asynchronous reset, active low
    input  wire logic [W-1:0] i_sig,   // sampled levels
    output logic      [W-1:0] o_rise   // one-cycle pulse per low-to-high step
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] prev;                                // level seen one edge ago
    } rise_state_t;

    rise_state_t state_reg;                                // registered state
    rise_state_t state_next;                               // next state

    // remember the last level; the pulse itself is combinational
    always_comb begin
        state_next      = state_reg;
        state_next.prev = i_sig;
    end

    // reset to low so a level already high at release pulses once
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_rise = i_sig & ~state_reg.prev;

endmodule

// ---- serial_switch_array_control.sv ----
// control logic of a 32-channel switch array: serial load, latch, bank mode, standby, ahb-lite status
// Overview of operation
// - individual mode shifts serial input on clock rise
// - each latched bit drives its own switch
// - latch gate low makes latch transparent
// - latch gate rise captures and holds state
// - gate high, shifting leaves switches unchanged
// - clear turns all switches off in individual mode, over gate and clock
// - cascade output follows shift stage 31 in individual mode, low in bank mode
// - shared pin: latch gate low, bank enable high
// - mode low is bank, high individual
// - bank pick high evens on, low odds
// - bank enable low turns every switch off
// - standby low forces all switches off always
// - mode rising resets all shift stages
`timescale 1ns/10ps
module serial_switch_array_control (
    input  wire logic        i_clk,                        // 40 MHz system clock
    input  wire logic        i_rst_b,                      // asynchronous reset, active low
    // ----- control pins from the host controller -----
    input  wire logic        i_serial_clk,                 // shift clock, sampled on i_clk
    input  wire logic        i_serial_in_or_bank_pick,     // serial data, or bank pick in bank mode
    input  wire logic        i_latch_gate_or_bank_enable,  // latch gate (low active) or bank enable
    input  wire logic        i_switch_clear,               // clear, active high
    input  wire logic        i_mode_individual,            // high individual, low bank mode
    input  wire logic        i_low_power_hold_n,           // standby when low
    output logic [31:0]      o_switch,                     // switch drive, bit n is switch n
    output logic             o_cascade_out,                // copy of last shift stage, low in bank mode
    output logic             o_wake_ready,                 // wake-up time elapsed since release
    // ----- ahb-lite slave -----
    input  wire logic        i_hsel,                       // slave select
    input  wire logic [31:0] i_haddr,                      // byte address
    input  wire logic [1:0]  i_htrans,                     // transfer type
    input  wire logic        i_hwrite,                     // write when high
    input  wire logic [2:0]  i_hsize,                      // transfer size, word only
    input  wire logic [31:0] i_hwdata,                     // write data
    input  wire logic        i_hready,                     // bus ready in
    output logic [31:0]      o_hrdata,                     // read data
    output logic             o_hreadyout,                  // slave ready out
    output logic             o_hresp                       // response, always okay
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0]                          shift;       // shift stages 0 to 31
        logic [31:0]                          latch;       // latch stage behind the shift register
        logic [31:0]                          sw;          // switch drive as applied
        logic                                 cascade;     // cascade output
        logic [1:0]                           ctrl;        // software control bits
        logic [switch_array_pkg::WAKE_W-1:0]  wake_cnt;    // cycles since standby release
        logic                                 wake_ok;     // wake-up time done
        logic                                 wr_pend;     // write data phase pending
        logic [7:0]                           wr_addr;     // address of pending write
        logic [31:0]                          rdata;       // read data for the data phase
    } ctl_state_t;

    ctl_state_t state_reg;                                 // registered state
    ctl_state_t state_next;                                // next state

    // ----------------------------------------------------------------
    // edge detection on the serial clock and the mode pin
    // ----------------------------------------------------------------
    logic [1:0] rise;                                      // bit 0 serial clock, bit 1 mode

    rise_detect #(
        .W (2)
    ) u_rise (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_sig   ({i_mode_individual, i_serial_clk}),
        .o_rise  (rise)
    );

    // ----------------------------------------------------------------
    // decoded input meanings
    // ----------------------------------------------------------------
    logic        standby;                                  // pin or software standby
    logic        clear_any;                                // pin or software clear
    logic        gate_open;                                // latch transparent in individual mode
    logic        bank_en;                                  // bank enable in bank mode
    logic        bus_take;                                 // ahb address phase accepted
    logic [7:0]  bus_addr;                                 // low byte of the address

    always_comb begin
        standby   = !i_low_power_hold_n
                    || state_reg.ctrl[switch_array_pkg::CTRL_SOFT_STANDBY];
        clear_any = i_switch_clear
                    || state_reg.ctrl[switch_array_pkg::CTRL_SOFT_CLEAR];
        gate_open = !i_latch_gate_or_bank_enable;
        bank_en   = i_latch_gate_or_bank_enable;
        bus_take  = i_hsel && i_htrans[1] && i_hready;
        bus_addr  = i_haddr[7:0];
    end

    // ----------------------------------------------------------------
    // register read mux, sampled in the address phase
    // ----------------------------------------------------------------
    function automatic logic [31:0] read_word(input logic [7:0] addr, input ctl_state_t s,
                                              input logic mode_ind, input logic low_power_hold_n);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (addr)
            switch_array_pkg::ADDR_CTRL:   w = {30'h0000_0000, s.ctrl};
            switch_array_pkg::ADDR_STATUS: begin
                w[switch_array_pkg::STAT_MODE_IND] = mode_ind;
                w[switch_array_pkg::STAT_STANDBY]  = low_power_hold_n;
                w[switch_array_pkg::STAT_WAKE_OK]  = s.wake_ok;
                w[switch_array_pkg::STAT_CASCADE]  = s.cascade;
            end
            switch_array_pkg::ADDR_SHIFT:  w = s.shift;
            switch_array_pkg::ADDR_LATCH:  w = s.latch;
            switch_array_pkg::ADDR_SWITCH: w = s.sw;
            // unmapped addresses read zero and answer okay
            default:                       w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;

        // shift register: mode rising wins over a coincident clock edge
        if (rise[1]) begin
            state_next.shift = 32'h0000_0000;
        end else if (i_mode_individual && rise[0]) begin
            // new bit enters stage 0, older bits move toward stage 31
            state_next.shift = {state_reg.shift[switch_array_pkg::LAST_STAGE-1:0],
                                i_serial_in_or_bank_pick};
        end

        // latch only works in individual mode; bank mode leaves it alone
        if (i_mode_individual) begin
            if (clear_any) begin
                state_next.latch = switch_array_pkg::ALL_OFF;
            end else if (gate_open) begin
                // transparent: follows the shift stages as they change
                state_next.latch = state_next.shift;
            end else begin
                // gate high: whatever was there at the rising edge stays
                state_next.latch = state_reg.latch;
            end
        end

        // switch drive, standby overrides every mode and pin
        if (standby) begin
            state_next.sw = switch_array_pkg::ALL_OFF;
        end else if (i_mode_individual) begin
            if (clear_any) begin
                state_next.sw = switch_array_pkg::ALL_OFF;
            end else begin
                state_next.sw = state_next.latch;
            end
        end else if (bank_en) begin
            if (i_serial_in_or_bank_pick) begin
                state_next.sw = switch_array_pkg::EVEN_MASK;
            end else begin
                state_next.sw = switch_array_pkg::ODD_MASK;
            end
        end else begin
            state_next.sw = switch_array_pkg::ALL_OFF;
        end

        // cascade repeats the last stage, only meaningful in individual mode
        state_next.cascade = i_mode_individual
                             && state_next.shift[switch_array_pkg::LAST_STAGE];

        // wake-up timer restarts on every standby and saturates once done
        if (standby) begin
            state_next.wake_cnt = '0;
            state_next.wake_ok  = 1'b0;
        end else if (state_reg.wake_cnt
                     == switch_array_pkg::WAKE_W'(switch_array_pkg::WAKE_CYC - 1)) begin
            state_next.wake_ok  = 1'b1;
        end else begin
            state_next.wake_cnt = state_reg.wake_cnt + switch_array_pkg::WAKE_W'(1);
        end

        // bus data phase: a pending write lands now
        if (state_reg.wr_pend && i_hready) begin
            state_next.wr_pend = 1'b0;
            if (state_reg.wr_addr == switch_array_pkg::ADDR_CTRL) begin
                state_next.ctrl = i_hwdata[1:0];
            end
        end

        // bus address phase: latch writes, prepare read data
        if (bus_take) begin
            state_next.wr_pend = i_hwrite;
            state_next.wr_addr = bus_addr;
            state_next.rdata   = i_hwrite ? 32'h0000_0000
                                          : read_word(bus_addr, state_reg, i_mode_individual, standby);
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // all switches open after reset: the safe state for the array
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg.shift    <= 32'h0000_0000;
            state_reg.latch    <= 32'h0000_0000;
            state_reg.sw       <= switch_array_pkg::ALL_OFF;
            state_reg.cascade  <= 1'b0;
            state_reg.ctrl     <= switch_array_pkg::CTRL_RESET;
            state_reg.wake_cnt <= '0;
            state_reg.wake_ok  <= 1'b0;
            state_reg.wr_pend  <= 1'b0;
            state_reg.wr_addr  <= 8'h00;
            state_reg.rdata    <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_switch      = state_reg.sw;
    assign o_cascade_out = state_reg.cascade;
    assign o_wake_ready  = state_reg.wake_ok;
    assign o_hrdata      = state_reg.rdata;
    // no wait states: every access completes in one data-phase cycle
    assign o_hreadyout   = 1'b1;
    assign o_hresp       = switch_array_pkg::HRESP_OKAY;

    // hsize is accepted as given; only word accesses are supported
    logic unused_hsize;                                    // keeps the input read
    assign unused_hsize  = ^i_hsize;

endmodule

// ---- serial_switch_array_control_props.sv ----
// pin-side assertions, switch array control
`timescale 1ns/10ps
module serial_switch_array_control_props (
    input wire logic        i_clk,                       // clock
    input wire logic        i_rst_b,                     // reset, active low
    input wire logic        i_serial_clk,                // shift clock
    input wire logic        i_serial_in_or_bank_pick,    // data or bank pick
    input wire logic        i_latch_gate_or_bank_enable, // gate or enable
    input wire logic        i_switch_clear,              // clear
    input wire logic        i_mode_individual,           // mode select
    input wire logic        i_low_power_hold_n,          // standby when low
    input wire logic [31:0] o_switch,                    // switch drive
    input wire logic        o_cascade_out,               // cascade output
    input wire logic        o_wake_ready                 // wake flag
);
    // ------------------------------------------------------------
    // switch and cascade behaviour, one clock domain
    // ------------------------------------------------------------
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // individual mode, awake and not clearing
    wire logic run  = i_mode_individual && i_low_power_hold_n && !i_switch_clear;
    // bank mode, awake and enabled
    wire logic bank = !i_mode_individual && i_low_power_hold_n && i_latch_gate_or_bank_enable;
    a_gate_freeze: assert property ((run && i_latch_gate_or_bank_enable) [*2] |=> $stable(o_switch))
        else $error("switches moved with gate high");
    // mode rise zeroes stages: kept out
    a_gate_open: assert property (
        run && $past(i_mode_individual) && !i_latch_gate_or_bank_enable |=> o_switch[31] == o_cascade_out)
        else $error("open latch not following last stage");
    a_cascade_still: assert property (
        i_mode_individual && $past(i_mode_individual) && !$rose(i_serial_clk) |=> $stable(o_cascade_out))
        else $error("cascade moved without a shift");
    a_mode_zero: assert property ($rose(i_mode_individual) |=> !o_cascade_out)
        else $error("mode rise kept stage data");
    a_clear_wins: assert property (
        i_mode_individual && i_switch_clear |=> o_switch == switch_array_pkg::ALL_OFF)
        else $error("clear left switches on");
    a_standby_off: assert property (
        !i_low_power_hold_n |=> o_switch == switch_array_pkg::ALL_OFF && !o_wake_ready)
        else $error("standby left switches on");
    a_bank_pick: assert property (
        bank |=> o_switch == ($past(i_serial_in_or_bank_pick) ? switch_array_pkg::EVEN_MASK : switch_array_pkg::ODD_MASK))
        else $error("bank pick gave wrong half");
    a_bank_off: assert property (
        !i_mode_individual && !i_latch_gate_or_bank_enable |=> o_switch == switch_array_pkg::ALL_OFF)
        else $error("disabled bank left switches on");
    cover property (i_mode_individual && i_switch_clear);
    cover property (bank);
    cover property (run && $rose(i_latch_gate_or_bank_enable));
endmodule

// ---- sw_host_model.sv ----
// host model driving the serial and control pins
`timescale 1ns/10ps
module sw_host_model (
    input  wire logic i_clk,              // system clock
    output logic      o_serial_clk,       // shift clock, still between frames
    output logic      o_data_or_pick,     // serial data or bank pick
    output logic      o_gate_or_enable,   // latch gate or bank enable
    output logic      o_clear,            // clear, active high
    output logic      o_mode_individual,  // mode select
    output logic      o_low_power_hold_n  // standby when low
);
    // ------------------------------------------------------------
    // pin tasks, every change lands just after a rising edge
    // ------------------------------------------------------------
    // power-up levels: standby, bank mode, gate high, clock still
    initial begin
        {o_serial_clk, o_data_or_pick, o_gate_or_enable, o_clear, o_mode_individual, o_low_power_hold_n} = 6'h08;
    end
    // static control levels, all in one step
    task automatic set_pins(input logic mode, input logic gate, input logic pick, input logic clr, input logic hold);
        @(posedge i_clk);
        {o_mode_individual, o_gate_or_enable, o_data_or_pick, o_clear, o_low_power_hold_n} <= {mode, gate, pick, clr, hold};
    endtask
    // bit 31 first, so bit n ends in stage n
    task automatic shift_word(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            @(posedge i_clk);
            o_serial_clk   <= 1'h0;
            o_data_or_pick <= w[i];
            @(posedge i_clk);
            o_serial_clk   <= 1'h1;
        end
        @(posedge i_clk);
        o_serial_clk   <= 1'h0;
        o_data_or_pick <= ~w[0];            // then move data off the last bit
    endtask
    // gate low for one sample, then high
    task automatic pulse_gate();
        @(posedge i_clk);
        o_gate_or_enable <= 1'h0;
        @(posedge i_clk);
        o_gate_or_enable <= 1'h1;
    endtask
endmodule

// ---- tb_top.sv ----
// switch array control testbench
`timescale 1ns/10ps
module tb_top;
    // ------------------------------------------------------------
    // signals, patterns and counters
    // ------------------------------------------------------------
    localparam logic [31:0] pat_a = 32'hA5C3_0F81; // first frame
    localparam logic [31:0] pat_b = 32'h9E37_1B64; // second frame
    localparam logic [31:0] pat_c = 32'h3C96_E10B; // open-gate frame
    logic        i_clk; // 40 MHz clock
    logic        i_rst_b; // reset, active low
    logic        ser_clk, data_pick, gate_en, clear, mode_ind, hold_n; // host pins
    logic [31:0] sw, haddr, hwdata, hrdata; // switches and bus words
    logic        cascade, wake_ready, hsel, hwrite, hreadyout, hresp; // flags and bus controls
    logic [1:0]  htrans; // bus transfer type
    logic [2:0]  hsize; // bus size, word only
    int          error_cnt   = 0; // mismatches
    int          checks_done = 0; // comparisons
    int          cyc         = 0; // cycles for the hang limit
    serial_switch_array_control i_serial_switch_array_control (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_serial_clk(ser_clk), .i_serial_in_or_bank_pick(data_pick),
        .i_latch_gate_or_bank_enable(gate_en), .i_switch_clear(clear), .i_mode_individual(mode_ind),
        .i_low_power_hold_n(hold_n), .o_switch(sw), .o_cascade_out(cascade), .o_wake_ready(wake_ready),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp));
    sw_host_model i_sw_host_model (.i_clk(i_clk), .o_serial_clk(ser_clk), .o_data_or_pick(data_pick),
        .o_gate_or_enable(gate_en), .o_clear(clear), .o_mode_individual(mode_ind), .o_low_power_hold_n(hold_n));
    // ------------------------------------------------------------
    // clock, hang limit and shared tasks
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'h0;
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic print_verdict();
        $display("checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // run needs ~800 cycles
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // flags come zero-extended
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // n edges, then past their updates
    task automatic settle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic see_sw(input string what, input logic [31:0] exp);
        settle(2);
        cmp(what, exp, sw);
    endtask
    // one word; each phase held until hready high
    task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge i_clk);
        hsel   <= 1'h1;
        haddr  <= {24'h00_0000, addr};
        htrans <= switch_array_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge i_clk);
        while (hreadyout !== 1'h1) @(posedge i_clk);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge i_clk);
        while (hreadyout !== 1'h1) @(posedge i_clk);
        rd = hrdata;
        cmp("bus response", 32'(switch_array_pkg::HRESP_OKAY), 32'(hresp));
    endtask
    task automatic rd_cmp(input string what, input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        ahb(1'h0, addr, 32'h0000_0000, rd);
        cmp(what, exp, rd);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        logic [31:0] rd;                                                 // discarded write answer
        {i_rst_b, hsel, hwrite, htrans, hsize} = 8'h02;
        {haddr, hwdata} = 64'h0000_0000_0000_0000;
        repeat (4) @(posedge i_clk);
        i_rst_b <= 1'h1;
        settle(1);
        cmp("switches after reset", switch_array_pkg::ALL_OFF, sw);
        i_sw_host_model.set_pins(1'h1, 1'h1, 1'h0, 1'h0, 1'h1);
        settle(switch_array_pkg::WAKE_CYC + 2);
        cmp("wake flag", 32'h0000_0001, 32'(wake_ready));
        // gate high: no change until the gate pulse
        i_sw_host_model.shift_word(pat_a);
        see_sw("switches with gate high", switch_array_pkg::ALL_OFF);
        cmp("cascade", 32'(pat_a[31]), 32'(cascade));
        i_sw_host_model.pulse_gate();
        see_sw("latched switches", pat_a);
        i_sw_host_model.shift_word(pat_b);
        see_sw("held switches", pat_a);
        rd_cmp("shift contents", switch_array_pkg::ADDR_SHIFT, pat_b);
        rd_cmp("latch contents", switch_array_pkg::ADDR_LATCH, pat_a);
        // open gate passes frames through
        i_sw_host_model.set_pins(1'h1, 1'h0, 1'h0, 1'h0, 1'h1);
        i_sw_host_model.shift_word(pat_c);
        see_sw("open latch", pat_c);
        // clear beats gate and clock, empties latch
        i_sw_host_model.set_pins(1'h1, 1'h0, 1'h0, 1'h1, 1'h1);
        i_sw_host_model.shift_word(pat_a);
        see_sw("switches under clear", switch_array_pkg::ALL_OFF);
        i_sw_host_model.set_pins(1'h1, 1'h1, 1'h0, 1'h0, 1'h1);
        see_sw("latch after clear", switch_array_pkg::ALL_OFF);
        // bank mode: every enable and pick level
        for (int i = 0; i < 4; i++) begin
            i_sw_host_model.set_pins(1'h0, i[1], i[0], 1'h0, 1'h1);
            rd = i[1] ? (i[0] ? switch_array_pkg::EVEN_MASK : switch_array_pkg::ODD_MASK) : switch_array_pkg::ALL_OFF;
            see_sw("bank switches", rd);
        end
        // mode rise zeroes the stages
        i_sw_host_model.set_pins(1'h1, 1'h1, 1'h0, 1'h0, 1'h1);
        settle(2);
        cmp("cascade after mode rise", 32'h0000_0000, 32'(cascade));
        rd_cmp("shift after mode rise", switch_array_pkg::ADDR_SHIFT, 32'h0000_0000);
        // standby forces all off; latch survives
        i_sw_host_model.shift_word(pat_b);
        i_sw_host_model.pulse_gate();
        i_sw_host_model.set_pins(1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
        see_sw("switches in standby", switch_array_pkg::ALL_OFF);
        cmp("wake flag in standby", 32'h0000_0000, 32'(wake_ready));
        i_sw_host_model.set_pins(1'h1, 1'h1, 1'h0, 1'h0, 1'h1);
        rd_cmp("status", switch_array_pkg::ADDR_STATUS, {28'h000_0000, pat_b[31], 3'h1});
        see_sw("switches after standby", pat_b);
        // control bits, read-only and unmapped
        ahb(1'h1, switch_array_pkg::ADDR_CTRL, 32'hFFFF_FFFC, rd);
        rd_cmp("control readback", switch_array_pkg::ADDR_CTRL, 32'h0000_0000);
        ahb(1'h1, switch_array_pkg::ADDR_SHIFT, 32'hFFFF_FFFF, rd);
        rd_cmp("read-only shift", switch_array_pkg::ADDR_SHIFT, pat_b);
        rd_cmp("unmapped read", 8'h40, 32'h0000_0000);
        print_verdict();
    end
endmodule
bind serial_switch_array_control serial_switch_array_control_props i_serial_switch_array_control_props (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_serial_clk(i_serial_clk), .i_serial_in_or_bank_pick(i_serial_in_or_bank_pick),
    .i_latch_gate_or_bank_enable(i_latch_gate_or_bank_enable), .i_switch_clear(i_switch_clear),
    .i_mode_individual(i_mode_individual), .i_low_power_hold_n(i_low_power_hold_n), .o_switch(o_switch),
    .o_cascade_out(o_cascade_out), .o_wake_ready(o_wake_ready));
